// ==== inc/tmcb_consts.vh ====
// constants for the trigger module csr bank
`ifndef TMCB_CONSTS_VH
`define TMCB_CONSTS_VH
// register addresses
`define TMCB_ADDR_SCTX      12'h5a8
`define TMCB_ADDR_HCTX      12'h6a8
`define TMCB_ADDR_DATA2     12'h7a2
`define TMCB_ADDR_DATA3     12'h7a3
`define TMCB_ADDR_INFO      12'h7a4
`define TMCB_ADDR_GATE      12'h7a5
`define TMCB_ADDR_MCTX      12'h7a8
`define TMCB_ADDR_LSCTX     12'h7aa
// gate field positions
`define TMCB_GATE_PREV_BIT  7
`define TMCB_GATE_EN_BIT    3
// capability word layout
`define TMCB_VER_LSB        24
`define TMCB_VER_W          8
`define TMCB_INFO_W         16
`define TMCB_INFO_ABSENT    16'h0001
// state-enable gate bit
`define TMCB_SE_BIT         57
// privilege encodings
`define TMCB_PRV_U          2'h0
`define TMCB_PRV_S          2'h1
`define TMCB_PRV_M          2'h3
// reset values
`define TMCB_RST_ZERO       64'h0
`endif

// ==== design/tmcb_priv_check.v ====
// privilege gating for each register address
`timescale 1ns/1ps
`include "tmcb_consts.vh"
module tmcb_priv_check #(
	parameter HAS_H       = 1,
	parameter HAS_STATEEN = 1
) (
	input  wire [11:0] addr,
	input  wire [1:0]  priv,
	input  wire        virt,
	input  wire        dbg_mode,
	input  wire        mse57,
	input  wire        hse57,
	output reg         mapped,
	output reg         allowed
);
	// mode decode
	wire m_or_d = dbg_mode | (priv == `TMCB_PRV_M);
	wire hs     = ~dbg_mode & (priv == `TMCB_PRV_S) & ~virt;
	wire vs     = ~dbg_mode & (priv == `TMCB_PRV_S) & virt;
	wire me     = (HAS_STATEEN == 0) | mse57;
	wire he     = (HAS_STATEEN == 0) | hse57 | (HAS_H == 0);

	// per-address allowance
	always @* begin
		mapped  = 1'b1;
		allowed = 1'b0;
		case (addr)
			`TMCB_ADDR_DATA2, `TMCB_ADDR_DATA3, `TMCB_ADDR_INFO: allowed = m_or_d;
			`TMCB_ADDR_GATE:  allowed = m_or_d; // [RULE10]
			`TMCB_ADDR_MCTX:  allowed = m_or_d; // [RULE19]
			`TMCB_ADDR_HCTX: begin
				mapped  = (HAS_H != 0); // [RULE15]
				allowed = mapped & (m_or_d | (hs & me)); // [RULE16]
			end
			`TMCB_ADDR_SCTX:  allowed = m_or_d | (hs & me) | (vs & me & he); // [RULE17]
			`TMCB_ADDR_LSCTX: allowed = m_or_d | (hs & me); // [RULE21] virtualised supervisor kept out
			default: mapped = 1'b0;
		endcase
	end
endmodule // tmcb_priv_check

// ==== design/tmcb_csr_bank.v ====
// trigger module csr bank: data words, capability, gate, contexts
// Function
// [RULE1] per-trigger registers follow the selected index; reset applies per trigger.
// [RULE2] disabled trigger accepts any value supported by its types in data words.
// [RULE3] narrow-width writes to data two and three are sign-extended.
// [RULE4] writes to the capability word change nothing.
// [RULE5] capability word: 8-bit version in bits 31..24, zero above bit 15 otherwise.
// [RULE6] version 0 means the older trigger behaviour.
// [RULE7] info bit N set when selected trigger supports type N.
// [RULE8] nonexistent selected trigger reads info as 1.
// [RULE9] capability word may be omitted; debugger then reads type from config word.
// [RULE10] trigger gate accessible only in machine or debug mode.
// [RULE11] gate: previous enable bit 7, enable bit 3, reset zero, rest zero.
// [RULE12] trap into machine mode saves enable to previous and clears enable.
// [RULE13] machine trap return restores enable from previous.
// [RULE14] enable 0 blocks action-0 triggers in machine mode.
// [RULE15] hypervisor context exists only with hypervisor, aliasing machine context.
// [RULE16] hypervisor context only in HS, machine, debug; HS gated by state-enable bit 57.
// [RULE17] supervisor context in S/HS, VS, M, debug; gated by both bit 57s.
// [RULE18] supervisor context resets zero; upper bits may be tied zero.
// [RULE19] machine context reachable only in machine and debug mode.
// [RULE20] machine context resets zero; recommended widths 6/13 or 7/14.
// [RULE21] legacy mirror aliases supervisor context; S/HS, M, debug only.
// [RULE22] unsupported index may point at a type-zero trigger.
// [RULE23] disallowed access raises illegal instruction, register unchanged.
`timescale 1ns/1ps
`include "tmcb_consts.vh"
module tmcb_csr_bank #(
	parameter NTRIG       = 4,
	parameter IDXW        = 2,
	parameter NATIVE_REGISTER_WIDTH        = 64,
	parameter DEBUG_REGISTER_WIDTH       = 64,
	parameter HAS_H       = 1,
	parameter HAS_STATEEN = 1,
	parameter SCTX_W      = 32,
	parameter MCTX_W      = 14,
	parameter [7:0]  VERSION    = 8'h01,
	parameter [15:0] TYPES_MASK = 16'h8040
) (
	input  wire              clk,
	input  wire              nrst,
	input  wire [IDXW-1:0]   sel_idx,
	input  wire              sel_disabled,
	input  wire              csr_req,
	input  wire              csr_we,
	input  wire [11:0]       csr_addr,
	input  wire [NATIVE_REGISTER_WIDTH-1:0]   csr_wdata,
	input  wire [1:0]        priv,
	input  wire              virt,
	input  wire              dbg_mode,
	input  wire              mse57,
	input  wire              hse57,
	input  wire              trap_to_m,
	input  wire              mret,
	output reg  [NATIVE_REGISTER_WIDTH-1:0]   csr_rdata,
	output reg               csr_ack,
	output reg               csr_illegal,
	output reg               m_trig_enable,
	output reg  [NTRIG*DEBUG_REGISTER_WIDTH-1:0] data2_flat,
	output reg  [NTRIG*DEBUG_REGISTER_WIDTH-1:0] data3_flat,
	output reg  [SCTX_W-1:0] sctx_out,
	output reg  [MCTX_W-1:0] mctx_out
);
	// ==========================================
	// storage
	reg [DEBUG_REGISTER_WIDTH-1:0]  data2 [0:NTRIG-1];
	reg [DEBUG_REGISTER_WIDTH-1:0]  data3 [0:NTRIG-1];
	reg              gate_en;
	reg              gate_prev;
	reg [SCTX_W-1:0] sctx;
	reg [MCTX_W-1:0] mctx;
	wire             mapped;
	wire             allowed;
	integer          i;

	// sign extension of a narrow write
	function [DEBUG_REGISTER_WIDTH-1:0] sext;
		input [NATIVE_REGISTER_WIDTH-1:0]       v;
		reg   [DEBUG_REGISTER_WIDTH+NATIVE_REGISTER_WIDTH-1:0] w;
		begin
			w    = {{DEBUG_REGISTER_WIDTH{v[NATIVE_REGISTER_WIDTH-1]}}, v}; // [RULE3] sign copies above the written word
			sext = w[DEBUG_REGISTER_WIDTH-1:0];
		end
	endfunction

	// zero-extend a field into a word
	function [NATIVE_REGISTER_WIDTH-1:0] zext;
		input [63:0] v;
		begin
			zext = v[NATIVE_REGISTER_WIDTH-1:0];
		end
	endfunction

	// ==========================================
	// access check
	tmcb_priv_check #(
		.HAS_H       (HAS_H),
		.HAS_STATEEN (HAS_STATEEN)
	) u_priv (
		.addr     (csr_addr),
		.priv     (priv),
		.virt     (virt),
		.dbg_mode (dbg_mode),
		.mse57    (mse57),
		.hse57    (hse57),
		.mapped   (mapped),
		.allowed  (allowed)
	);

	wire idx_ok = ({1'b0, sel_idx} < NTRIG);
	wire do_wr  = csr_req & csr_we & mapped & allowed; // [RULE23]

	// capability word for the selected trigger
	wire [15:0] info_f = idx_ok ? TYPES_MASK : `TMCB_INFO_ABSENT; // [RULE7] [RULE8] [RULE22]
	wire [31:0] info_w = {VERSION, 8'h00, info_f}; // [RULE5] [RULE6] [RULE9] word always present

	// ==========================================
	// read mux
	reg [NATIVE_REGISTER_WIDTH-1:0] next_rdata;
	always @* begin
		next_rdata = {NATIVE_REGISTER_WIDTH{1'b0}};
		case (csr_addr)
			`TMCB_ADDR_DATA2: if (idx_ok) next_rdata = data2[sel_idx][NATIVE_REGISTER_WIDTH-1:0]; // [RULE1]
			`TMCB_ADDR_DATA3: if (idx_ok) next_rdata = data3[sel_idx][NATIVE_REGISTER_WIDTH-1:0];
			`TMCB_ADDR_INFO:  next_rdata = zext({32'h0, info_w});
			`TMCB_ADDR_GATE:  begin
				next_rdata[`TMCB_GATE_PREV_BIT] = gate_prev; // [RULE11]
				next_rdata[`TMCB_GATE_EN_BIT]   = gate_en;
			end
			`TMCB_ADDR_MCTX, `TMCB_ADDR_HCTX: next_rdata = zext({{(64-MCTX_W){1'b0}}, mctx}); // [RULE15]
			`TMCB_ADDR_SCTX, `TMCB_ADDR_LSCTX: next_rdata = zext({{(64-SCTX_W){1'b0}}, sctx}); // [RULE21]
			default: next_rdata = {NATIVE_REGISTER_WIDTH{1'b0}};
		endcase
	end

	// ==========================================
	// answer registers
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			csr_rdata   <= {NATIVE_REGISTER_WIDTH{1'b0}};
			csr_ack     <= 1'b0;
			csr_illegal <= 1'b0;
		end else begin
			csr_ack     <= csr_req;
			csr_illegal <= csr_req & ~(mapped & allowed); // [RULE23]
			csr_rdata   <= (csr_req & mapped & allowed) ? next_rdata : {NATIVE_REGISTER_WIDTH{1'b0}};
		end
	end

	// ==========================================
	// per-trigger data words
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (i = 0; i < NTRIG; i = i + 1) begin
				data2[i] <= {DEBUG_REGISTER_WIDTH{1'b0}}; // [RULE1]
				data3[i] <= {DEBUG_REGISTER_WIDTH{1'b0}};
			end
		end else if (do_wr && idx_ok) begin
			// any value stored; a disabled trigger takes it all, sel_disabled is not used anywhere in this module
			if (csr_addr == `TMCB_ADDR_DATA2)
				data2[sel_idx] <= sext(csr_wdata); // [RULE2] [RULE3]
			if (csr_addr == `TMCB_ADDR_DATA3)
				data3[sel_idx] <= sext(csr_wdata); // [RULE2] [RULE3]
			// capability word writes fall through and change nothing [RULE4]
		end
	end

	// flattened view for match logic
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			data2_flat <= {(NTRIG*DEBUG_REGISTER_WIDTH){1'b0}};
			data3_flat <= {(NTRIG*DEBUG_REGISTER_WIDTH){1'b0}};
		end else begin
			for (i = 0; i < NTRIG; i = i + 1) begin
				data2_flat[i*DEBUG_REGISTER_WIDTH +: DEBUG_REGISTER_WIDTH] <= data2[i];
				data3_flat[i*DEBUG_REGISTER_WIDTH +: DEBUG_REGISTER_WIDTH] <= data3[i];
			end
		end
	end

	// ==========================================
	// machine trigger gate
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gate_en   <= 1'b0; // [RULE11]
			gate_prev <= 1'b0;
		end else if (trap_to_m) begin
			gate_prev <= gate_en; // [RULE12]
			gate_en   <= 1'b0;
		end else if (mret) begin
			gate_en   <= gate_prev; // [RULE13]
		end else if (do_wr && csr_addr == `TMCB_ADDR_GATE) begin
			gate_en   <= csr_wdata[`TMCB_GATE_EN_BIT];
			gate_prev <= csr_wdata[`TMCB_GATE_PREV_BIT];
		end
	end

	// enable level for action-0 triggers in machine mode
	always @(posedge clk or negedge nrst) begin
		if (!nrst)
			m_trig_enable <= 1'b0;
		else if (trap_to_m)
			m_trig_enable <= 1'b0; // [RULE14]
		else if (mret)
			m_trig_enable <= gate_prev;
		else if (do_wr && csr_addr == `TMCB_ADDR_GATE)
			m_trig_enable <= csr_wdata[`TMCB_GATE_EN_BIT];
		else
			m_trig_enable <= gate_en; // [RULE14]
	end

	// ==========================================
	// context numbers
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sctx <= {SCTX_W{1'b0}}; // [RULE18]
			mctx <= {MCTX_W{1'b0}}; // [RULE20]
		end else if (do_wr) begin
			if (csr_addr == `TMCB_ADDR_SCTX || csr_addr == `TMCB_ADDR_LSCTX)
				sctx <= csr_wdata[SCTX_W-1:0]; // [RULE21]
			if (csr_addr == `TMCB_ADDR_MCTX || csr_addr == `TMCB_ADDR_HCTX)
				mctx <= csr_wdata[MCTX_W-1:0]; // [RULE15] [RULE19]
		end
	end

	// context outputs to match logic
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sctx_out <= {SCTX_W{1'b0}};
			mctx_out <= {MCTX_W{1'b0}};
		end else begin
			sctx_out <= sctx;
			mctx_out <= mctx;
		end
	end
endmodule // tmcb_csr_bank

// ==== dv/tmcb_chk.sv ====
// assertion checker for the csr bank ports
`timescale 1ns/1ps
module tmcb_chk #(parameter NATIVE_REGISTER_WIDTH = 64) (
	input wire logic            clk,
	input wire logic            nrst,
	input wire logic            csr_req,
	input wire logic            csr_we,
	input wire logic [11:0]     csr_addr,
	input wire logic [1:0]      priv,
	input wire logic            dbg_mode,
	input wire logic            trap_to_m,
	input wire logic            mret,
	input wire logic [NATIVE_REGISTER_WIDTH-1:0] csr_rdata,
	input wire logic            csr_ack,
	input wire logic            csr_illegal,
	input wire logic            m_trig_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// machine or debug mode, and plain reads
	wire mach = priv == 2'h3 || dbg_mode;
	wire rd   = csr_req && !csr_we;
	a_ack_one_cycle: assert property (csr_req |=> csr_ack) else $error("no ack");
	a_ack_no_req: assert property (!csr_req |=> !csr_ack) else $error("stray ack");
	a_gate_mode_only: assert property (csr_req && csr_addr == 12'h7a5 && !mach |=> csr_illegal) else $error("gate");
	a_ver_field: assert property (rd && csr_addr == 12'h7a4 && mach |=> csr_rdata[31:16] == 16'h0100) else $error("ver");
	a_gate_pad_zero: assert property (rd && csr_addr == 12'h7a5 && mach |=> (csr_rdata & ~{{(NATIVE_REGISTER_WIDTH-8){1'b0}}, 8'h88}) == 0)
		else $error("pad");
	a_trap_clears_en: assert property (trap_to_m ##1 (!mret && !csr_req) |=> !m_trig_enable) else $error("trap");
	a_mctx_mode_only: assert property (csr_req && csr_addr == 12'h7a8 && !mach |=> csr_illegal) else $error("mctx");
	a_hctx_user_denied: assert property (csr_req && csr_addr == 12'h6a8 && priv == 2'h0 && !dbg_mode |=> csr_illegal)
		else $error("hctx");
	a_illegal_no_data: assert property (csr_illegal |-> csr_rdata == 0) else $error("data");
	// main scenarios
	c_trap: cover property (trap_to_m);
	c_ret: cover property (mret);
	c_denied: cover property (csr_illegal);
endmodule // tmcb_chk
bind tmcb_csr_bank tmcb_chk #(.NATIVE_REGISTER_WIDTH(NATIVE_REGISTER_WIDTH)) tmcb_chk_i (.clk(clk), .nrst(nrst), .csr_req(csr_req), .csr_we(csr_we),
	.csr_addr(csr_addr), .priv(priv), .dbg_mode(dbg_mode), .trap_to_m(trap_to_m), .mret(mret),
	.csr_rdata(csr_rdata), .csr_ack(csr_ack), .csr_illegal(csr_illegal), .m_trig_enable(m_trig_enable));

// ==== dv/tmcb_hart_model.sv ====
// hart side model issuing csr accesses, traps and returns
`timescale 1ns/1ps
module tmcb_hart_model (
	input  wire logic        clk,
	input  wire logic        csr_ack,
	input  wire logic        csr_illegal,
	input  wire logic [31:0] csr_rdata,
	output logic             csr_req,
	output logic             csr_we,
	output logic [11:0]      csr_addr,
	output logic [31:0]      csr_wdata,
	output logic             trap_to_m,
	output logic             mret
);
	logic [31:0] rd;
	logic        ok;
	logic        il;
	// idle lines at time zero
	initial begin
		{csr_req, csr_we, trap_to_m, mret} = 4'h0;
		csr_addr = 12'h0;
		csr_wdata = 32'h0;
	end
	// one access, answer taken one cycle after the request
	task acc(input logic we, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		#1;
		{csr_req, csr_we, csr_addr, csr_wdata} = {1'b1, we, a, d};
		@(posedge clk);
		#1;
		{ok, il, rd} = {csr_ack, csr_illegal, csr_rdata};
		csr_req = 1'b0;
		{csr_addr, csr_wdata} = ~{a, d}; // no stale value once released
	endtask
	// one-cycle trap (t=1) or return (t=0)
	task pulse(input logic t);
		@(posedge clk);
		#1;
		{trap_to_m, mret} = {t, !t};
		@(posedge clk);
		#1;
		{trap_to_m, mret} = 2'h0;
	endtask
endmodule // tmcb_hart_model

// ==== dv/trigger_module_csr_bank_tb.sv ====
// self-checking bench for the csr bank
`timescale 1ns/1ps
module trigger_module_csr_bank_tb;
	logic         clk = 0;
	logic         nrst = 0;
	logic [1:0]   sel_idx = 0;
	logic [1:0]   priv = 3;
	logic         mse57 = 1;
	logic         virt = 1'b0;
	logic         dbg_mode = 1'b0;
	logic         hse57 = 1'b1;
	logic [31:0]  sctx_out;
	logic [13:0]  mctx_out;
	logic         csr_req, csr_we, trap_to_m, mret, csr_ack, csr_illegal, m_trig_enable;
	logic [11:0]  csr_addr;
	logic [31:0]  csr_wdata, csr_rdata, v[3];
	logic [191:0] data2_flat, data3_flat;
	int           mismatches = 0, cmp_count = 0, cyc = 0;
	always #2.5 clk = ~clk;
	tmcb_csr_bank #(.NTRIG(3), .NATIVE_REGISTER_WIDTH(32)) tmcb_csr_bank_i (.clk(clk), .nrst(nrst), .sel_idx(sel_idx),
		.sel_disabled(1'b0), .csr_req(csr_req), .csr_we(csr_we), .csr_addr(csr_addr), .csr_wdata(csr_wdata),
		.priv(priv), .virt(virt), .dbg_mode(dbg_mode), .mse57(mse57), .hse57(hse57), .trap_to_m(trap_to_m),
		.mret(mret), .csr_rdata(csr_rdata), .csr_ack(csr_ack), .csr_illegal(csr_illegal),
		.m_trig_enable(m_trig_enable), .data2_flat(data2_flat), .data3_flat(data3_flat),
		.sctx_out(sctx_out), .mctx_out(mctx_out));
	tmcb_hart_model hart_i (.clk(clk), .csr_ack(csr_ack), .csr_illegal(csr_illegal), .csr_rdata(csr_rdata),
		.csr_req(csr_req), .csr_we(csr_we), .csr_addr(csr_addr), .csr_wdata(csr_wdata),
		.trap_to_m(trap_to_m), .mret(mret));
	task report_and_stop;
		if (mismatches == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input string n, input logic [63:0] e, input logic [63:0] s);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	// access, then compare ack, denial and, for reads only, read data
	task ac(input logic we, input logic [11:0] a, input logic [31:0] d, input logic il, input logic [31:0] e);
		hart_i.acc(we, a, d);
		chk("ack", 1, hart_i.ok);
		chk("illegal", il, hart_i.il);
		if (!we)
			chk("rdata", e, hart_i.rd);
	endtask
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			report_and_stop;
		end
	end
	initial begin
		void'($urandom(94));
		repeat (20) @(posedge clk);
		#1 nrst = 1;
		ac(0, 12'h7a5, 0, 0, 0);
		ac(1, 12'h7a5, 32'hffffffff, 0, 0);
		ac(0, 12'h7a5, 0, 0, 32'h88);
		chk("mte", 1, m_trig_enable);
		hart_i.pulse(1);
		ac(0, 12'h7a5, 0, 0, 32'h80);
		chk("mte", 0, m_trig_enable);
		hart_i.pulse(0);
		ac(0, 12'h7a5, 0, 0, 32'h88);
		chk("mte", 1, m_trig_enable);
		ac(1, 12'h6a8, 32'h1234, 0, 0);
		ac(0, 12'h7a8, 0, 0, 32'h1234);
		chk("mctx_out", 14'h1234, mctx_out);
		ac(1, 12'h7a4, 32'hffffffff, 0, 0);
		ac(0, 12'h7a4, 0, 0, 32'h01008040);
		ac(0, 12'h7bf, 0, 1, 0);
		priv = 0;
		ac(1, 12'h7a5, 0, 1, 0);
		dbg_mode = 1'b1;
		ac(0, 12'h7a5, 0, 0, 32'h88);
		ac(0, 12'h7a8, 0, 0, 32'h1234);
		dbg_mode = 1'b0;
		ac(1, 12'h5a8, 1, 1, 0);
		ac(0, 12'h6a8, 0, 1, 0);
		priv = 1;
		ac(0, 12'h7a8, 0, 1, 0);
		ac(0, 12'h6a8, 0, 0, 32'h1234);
		ac(1, 12'h5a8, 32'h5, 0, 0);
		ac(0, 12'h7aa, 0, 0, 32'h5);
		chk("sctx_out", 5, sctx_out);
		virt = 1'b1;
		ac(0, 12'h7aa, 0, 1, 0);
		ac(0, 12'h6a8, 0, 1, 0);
		hse57 = 1'b0;
		ac(0, 12'h5a8, 0, 1, 0);
		hse57 = 1'b1;
		ac(0, 12'h5a8, 0, 0, 32'h5);
		virt = 1'b0;
		mse57 = 0;
		ac(0, 12'h5a8, 0, 1, 0);
		mse57 = 1;
		priv = 3;
		ac(0, 12'h7a5, 0, 0, 32'h88);
		for (int i = 0; i < 3; i++) begin
			sel_idx = 2'(i);
			v[i] = i ? $urandom : 32'h800000a5;
			ac(1, 12'h7a2, v[i], 0, 0);
			ac(1, 12'h7a3, ~v[i], 0, 0);
		end
		for (int i = 0; i < 3; i++) begin
			sel_idx = 2'(i);
			ac(0, 12'h7a2, 0, 0, v[i]);
			chk("data2", {{32{v[i][31]}}, v[i]}, data2_flat[i*64 +: 64]);
			chk("data3", {{32{~v[i][31]}}, ~v[i]}, data3_flat[i*64 +: 64]);
		end
		sel_idx = 3;
		hart_i.acc(0, 12'h7a4, 0);
		chk("info", 1, hart_i.rd[15:0]);
		// reset in mid-run: gate, both contexts, trigger 0 data two and enable level read back zero
		@(posedge clk);
		#1 nrst = 1'b0;
		repeat (2) @(posedge clk);
		#1 nrst = 1'b1;
		sel_idx = 2'd0;
		ac(0, 12'h7a5, 0, 0, 0);
		ac(0, 12'h5a8, 0, 0, 0);
		ac(0, 12'h7a8, 0, 0, 0);
		ac(0, 12'h7a2, 0, 0, 0);
		chk("mte", 0, m_trig_enable);
		report_and_stop;
	end
endmodule // trigger_module_csr_bank_tb
